// ===== hw/lhfr_defines.vh
// constants for the limp-home fault response and reference readout bank
// Function
// - timer field 00/01/10/11 selects 3.6, 7.2, 14.4, 28.8 ms fault timer
// - ch2 thermal fault: bit 0 auto-restart on hysteresis, 1 clears enable
// - ch2 high-side limit fault: bit 0 restart after timer, 1 latch off
// - ch2 low-side limit fault: bit 0 restart after timer, 1 latch off
// - ch1 thermal fault: bit 0 auto-restart on hysteresis, 1 clears enable
// - ch1 high-side limit fault: bit 0 restart after timer, 1 latch off
// - ch1 low-side limit fault: bit 0 restart after timer, 1 latch off
// - raw 10-bit reference code: bits 1:0 low register, 9:2 high register
// - one code step is 2.45/1023 volt
// - filtered reference readable: 8 msbs high register, 2 lsbs low
// - filtered low register updates only when filtered high is read
// - reference select 1 uses pin code as current setting, 0 registers
`ifndef LHFR_DEFINES_VH
`define LHFR_DEFINES_VH

`define LHFR_ADDR_CFG1       8'h1e
`define LHFR_ADDR_CFG2       8'h1f
`define LHFR_ADDR_RAW_LO     8'h20
`define LHFR_ADDR_RAW_HI     8'h21
`define LHFR_ADDR_FILT_LO    8'h22
`define LHFR_ADDR_FILT_HI    8'h23
`define LHFR_ADDR_CH1_CUR_LO 8'h24
`define LHFR_ADDR_CH1_CUR_HI 8'h25
`define LHFR_ADDR_CH2_CUR_LO 8'h26
`define LHFR_ADDR_CH2_CUR_HI 8'h27

`define LHFR_CFG1_CH1_EN     0
`define LHFR_CFG1_CH2_EN     3
`define LHFR_CFG1_EXT_SEL    6
`define LHFR_RESET_BYTE      8'h00

`define LHFR_CLK_KHZ         40000
`define LHFR_FT0_US          3600
`define LHFR_FT1_US          7200
`define LHFR_FT2_US          14400
`define LHFR_FT3_US          28800
// cycle counts at 40 MHz, sized to the 21-bit timer
`define LHFR_FT0_CYC         21'd144000
`define LHFR_FT1_CYC         21'd288000
`define LHFR_FT2_CYC         21'd576000
`define LHFR_FT3_CYC         21'd1152000
`define LHFR_FILT_SHIFT      3

`endif

// ===== hw/lhfr_bank.v
// limp-home config, fault response, timers and reference readout registers
`timescale 1ns/1ps
`default_nettype none
`include "lhfr_defines.vh"

module lhfr_bank #(
    parameter [20:0] FT0_CYC = `LHFR_FT0_CYC,
    parameter [20:0] FT1_CYC = `LHFR_FT1_CYC,
    parameter [20:0] FT2_CYC = `LHFR_FT2_CYC,
    parameter [20:0] FT3_CYC = `LHFR_FT3_CYC
) (
    input  wire        mclk_i,
    input  wire        reset_i,
    input  wire        wr_i,
    input  wire        rd_i,
    input  wire [7:0]  addr_i,
    input  wire [7:0]  wdata_i,
    output reg  [7:0]  rdata_o,
    input  wire        adc_valid_i,
    input  wire [9:0]  adc_code_i,
    input  wire [1:0]  thermal_fault_i,
    input  wire [1:0]  hs_limit_fault_i,
    input  wire [1:0]  ls_limit_fault_i,
    output reg  [1:0]  channel_run_o,
    output reg  [9:0]  ch1_current_setting_o,
    output reg  [9:0]  ch2_current_setting_o
);

// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
reg  [7:0]  cfg1_r;
reg  [7:0]  cfg2_r;
reg  [9:0]  ch1_cur_r;
reg  [9:0]  ch2_cur_r;
reg  [9:0]  raw_r;
reg  [12:0] filt_acc_r;
reg  [1:0]  filt_lo_r;
reg  [1:0]  therm_s1_r;
reg  [1:0]  therm_s2_r;
reg  [1:0]  hs_s1_r;
reg  [1:0]  hs_s2_r;
reg  [1:0]  ls_s1_r;
reg  [1:0]  ls_s2_r;
reg  [1:0]  therm_hold_r;
reg  [1:0]  switch_current_limit_wait_r;
reg  [20:0] timer1_r;
reg  [20:0] timer2_r;

wire [9:0]  filt_val = filt_acc_r[12:3];
wire [1:0]  limit_ev = hs_s2_r | ls_s2_r;
wire [1:0]  ch_en = {cfg1_r[`LHFR_CFG1_CH2_EN], cfg1_r[`LHFR_CFG1_CH1_EN]};

// ----------------------------------------------------------------
// helpers
// ----------------------------------------------------------------
function [20:0] ft_limit;
    input [1:0] sel;
    begin
        case (sel)
            2'b00:   ft_limit = FT0_CYC;
            2'b01:   ft_limit = FT1_CYC;
            2'b10:   ft_limit = FT2_CYC;
            default: ft_limit = FT3_CYC;
        endcase
    end
endfunction

// latch-off request of one channel given its three response bits
function latch_req;
    input ts_sel;
    input hs_sel;
    input ls_sel;
    input ts_ev;
    input hs_ev;
    input ls_ev;
    begin
        latch_req = (ts_sel & ts_ev) | (hs_sel & hs_ev) | (ls_sel & ls_ev);
    end
endfunction

wire ch1_latch = latch_req(cfg2_r[2], cfg2_r[1], cfg2_r[0],
                           therm_s2_r[0], hs_s2_r[0], ls_s2_r[0]);
wire ch2_latch = latch_req(cfg2_r[5], cfg2_r[4], cfg2_r[3],
                           therm_s2_r[1], hs_s2_r[1], ls_s2_r[1]);

// ----------------------------------------------------------------
// fault inputs come from the analog domain: two-stage synchronisers
// ----------------------------------------------------------------
always @(posedge mclk_i) begin
    if (reset_i) begin
        therm_s1_r <= 2'h0;
        therm_s2_r <= 2'h0;
        hs_s1_r    <= 2'h0;
        hs_s2_r    <= 2'h0;
        ls_s1_r    <= 2'h0;
        ls_s2_r    <= 2'h0;
    end else begin
        therm_s1_r <= thermal_fault_i;
        therm_s2_r <= therm_s1_r;
        hs_s1_r    <= hs_limit_fault_i;
        hs_s2_r    <= hs_s1_r;
        ls_s1_r    <= ls_limit_fault_i;
        ls_s2_r    <= ls_s1_r;
    end
end

// ----------------------------------------------------------------
// configuration writes; latch-off clears the enable bit
// ----------------------------------------------------------------
always @(posedge mclk_i) begin
    if (reset_i) begin
        cfg1_r    <= `LHFR_RESET_BYTE;
        cfg2_r    <= `LHFR_RESET_BYTE;
        ch1_cur_r <= 10'h000;
        ch2_cur_r <= 10'h000;
    end else begin
        if (wr_i) begin
            case (addr_i)
                `LHFR_ADDR_CFG1:       cfg1_r <= wdata_i;
                `LHFR_ADDR_CFG2:       cfg2_r <= wdata_i;
                `LHFR_ADDR_CH1_CUR_LO: ch1_cur_r[1:0] <= wdata_i[1:0];
                `LHFR_ADDR_CH1_CUR_HI: ch1_cur_r[9:2] <= wdata_i;
                `LHFR_ADDR_CH2_CUR_LO: ch2_cur_r[1:0] <= wdata_i[1:0];
                `LHFR_ADDR_CH2_CUR_HI: ch2_cur_r[9:2] <= wdata_i;
                default: ;
            endcase
        end
        // a fault in the same cycle as a host write still turns it off
        if (ch1_latch)
            cfg1_r[`LHFR_CFG1_CH1_EN] <= 1'b0;
        if (ch2_latch)
            cfg1_r[`LHFR_CFG1_CH2_EN] <= 1'b0;
    end
end

// ----------------------------------------------------------------
// auto-restart: thermal follows the hysteresis level, limit uses timer
// ----------------------------------------------------------------
always @(posedge mclk_i) begin
    if (reset_i) begin
        therm_hold_r <= 2'h0;
        switch_current_limit_wait_r  <= 2'h0;
        timer1_r     <= 21'h0;
        timer2_r     <= 21'h0;
    end else begin
        therm_hold_r <= therm_s2_r;
        if (limit_ev[0]) begin
            switch_current_limit_wait_r[0] <= 1'b1;
            timer1_r       <= 21'h0;
        end else if (switch_current_limit_wait_r[0]) begin
            if (timer1_r >= ft_limit(cfg2_r[7:6]) - 21'h1)
                switch_current_limit_wait_r[0] <= 1'b0;
            else
                timer1_r <= timer1_r + 21'h1;
        end
        if (limit_ev[1]) begin
            switch_current_limit_wait_r[1] <= 1'b1;
            timer2_r       <= 21'h0;
        end else if (switch_current_limit_wait_r[1]) begin
            if (timer2_r >= ft_limit(cfg2_r[7:6]) - 21'h1)
                switch_current_limit_wait_r[1] <= 1'b0;
            else
                timer2_r <= timer2_r + 21'h1;
        end
    end
end

// ----------------------------------------------------------------
// reference conversion, filter and snapshot
// ----------------------------------------------------------------
always @(posedge mclk_i) begin
    if (reset_i) begin
        raw_r      <= 10'h000;
        filt_acc_r <= 13'h0000;
        filt_lo_r  <= 2'h0;
    end else begin
        if (adc_valid_i) begin
            raw_r <= adc_code_i;
            // first-order low-pass, gain 1/8 per sample
            filt_acc_r <= filt_acc_r - {3'h0, filt_val}
                          + {3'h0, adc_code_i};
        end
        // reading the upper half freezes the lower half for a coherent pair
        if (rd_i && addr_i == `LHFR_ADDR_FILT_HI)
            filt_lo_r <= filt_val[1:0];
    end
end

// ----------------------------------------------------------------
// read data and channel outputs
// ----------------------------------------------------------------
always @(posedge mclk_i) begin
    if (reset_i) begin
        rdata_o               <= 8'h00;
        channel_run_o         <= 2'h0;
        ch1_current_setting_o <= 10'h000;
        ch2_current_setting_o <= 10'h000;
    end else begin
        if (rd_i) begin
            case (addr_i)
                `LHFR_ADDR_CFG1:       rdata_o <= cfg1_r;
                `LHFR_ADDR_CFG2:       rdata_o <= cfg2_r;
                `LHFR_ADDR_RAW_LO:     rdata_o <= {6'h00, raw_r[1:0]};
                `LHFR_ADDR_RAW_HI:     rdata_o <= raw_r[9:2];
                `LHFR_ADDR_FILT_LO:    rdata_o <= {6'h00, filt_lo_r};
                `LHFR_ADDR_FILT_HI:    rdata_o <= filt_val[9:2];
                `LHFR_ADDR_CH1_CUR_LO: rdata_o <= {6'h00, ch1_cur_r[1:0]};
                `LHFR_ADDR_CH1_CUR_HI: rdata_o <= ch1_cur_r[9:2];
                `LHFR_ADDR_CH2_CUR_LO: rdata_o <= {6'h00, ch2_cur_r[1:0]};
                `LHFR_ADDR_CH2_CUR_HI: rdata_o <= ch2_cur_r[9:2];
                default:               rdata_o <= 8'h00;
            endcase
        end
        // run only while enabled, no thermal fault held and no timer pending
        channel_run_o <= ch_en & ~therm_s2_r & ~therm_hold_r
                         & ~switch_current_limit_wait_r & ~limit_ev;
        if (cfg1_r[`LHFR_CFG1_EXT_SEL]) begin
            ch1_current_setting_o <= raw_r;
            ch2_current_setting_o <= raw_r;
        end else begin
            ch1_current_setting_o <= ch1_cur_r;
            ch2_current_setting_o <= ch2_cur_r;
        end
    end
end

endmodule // lhfr_bank
`default_nettype wire

// ===== testbench/lhfr_bank_assertions.sv
// concurrent checks on the ports of the limp-home register bank
`timescale 1ns/1ps
`default_nettype none
module lhfr_bank_assertions (
    input wire logic       mclk_i,
    input wire logic       reset_i,
    input wire logic       rd_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] rdata_o,
    input wire logic [1:0] thermal_fault_i,
    input wire logic [1:0] hs_limit_fault_i,
    input wire logic [1:0] ls_limit_fault_i,
    input wire logic [1:0] channel_run_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    sequence hi_rd; rd_i && addr_i == 8'h23; endsequence
    sequence lo_rd; rd_i && addr_i == 8'h22; endsequence
    chk_lo_snapshot_held: assert property (
        lo_rd ##1 lo_rd |=> $stable(rdata_o)) else $error("lower moved");
    chk_pair_lo_reserved: assert property (
        hi_rd ##1 lo_rd |=> rdata_o[7:2] == 6'h00) else $error("lo bits");
    chk_raw_lo_reserved: assert property (
        rd_i && addr_i == 8'h20 |=> rdata_o[7:2] == 6'h00) else $error("raw");
    chk_unmapped_zero: assert property (
        rd_i && (addr_i > 8'h27 || addr_i < 8'h1e) |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    chk_ch1_thermal_off: assert property (
        thermal_fault_i[0] [*4] |-> !channel_run_o[0]) else $error("ch1 ts");
    chk_ch2_thermal_off: assert property (
        thermal_fault_i[1] [*4] |-> !channel_run_o[1]) else $error("ch2 ts");
    chk_ch1_high_off: assert property (
        hs_limit_fault_i[0] [*4] |-> !channel_run_o[0]) else $error("ch1 hs");
    chk_ch2_low_off: assert property (
        ls_limit_fault_i[1] [*4] |-> !channel_run_o[1]) else $error("ch2 ls");
    chk_timer_holds_off: assert property (
        $fell(hs_limit_fault_i[1]) && !channel_run_o[1] |=>
        !channel_run_o[1] [*8]) else $error("restart before timer");
endmodule // lhfr_bank_assertions
bind lhfr_bank lhfr_bank_assertions chk_u (.mclk_i(mclk_i),
    .reset_i(reset_i), .rd_i(rd_i), .addr_i(addr_i), .rdata_o(rdata_o),
    .thermal_fault_i(thermal_fault_i), .hs_limit_fault_i(hs_limit_fault_i),
    .ls_limit_fault_i(ls_limit_fault_i), .channel_run_o(channel_run_o));
`default_nettype wire

// ===== testbench/lhfr_host.sv
// host model driving the register strobes of the bank
`timescale 1ns/1ps
`default_nettype none
module lhfr_host (
    input  wire logic       mclk_i,
    input  wire logic [7:0] rdata_i,
    output var  logic       wr_o,
    output var  logic       rd_o,
    output var  logic [7:0] addr_o,
    output var  logic [7:0] wdata_o
);
    initial {wr_o, rd_o, addr_o, wdata_o} = 18'h00000;
    // released bus shows inverted values, never a stale match
    task put(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        #1 {wr_o, addr_o, wdata_o} = {1'b1, a, d};
        @(posedge mclk_i);
        #1 {wr_o, addr_o, wdata_o} = {1'b0, ~a, ~d};
    endtask
    // reads on consecutive edges: upper then lower stays coherent
    task get(input logic [7:0] a, input logic [7:0] b,
             output logic [7:0] qa, output logic [7:0] qb);
        @(posedge mclk_i);
        #1 {rd_o, addr_o} = {1'b1, a};
        @(posedge mclk_i);
        #1 qa = rdata_i;
        addr_o = b;
        @(posedge mclk_i);
        #1 qb = rdata_i;
        {rd_o, addr_o} = {1'b0, ~b};
    endtask
endmodule // lhfr_host
`default_nettype wire

// ===== testbench/tb.sv
// self-checking bench for the limp-home fault and reference bank
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic       mclk_i = 1'b0, reset_i = 1'b1, wr_i, rd_i, adc_valid_i = 1'b0;
    logic [7:0] addr_i, wdata_i, rdata_o, qa, qb;
    logic [9:0] adc_code_i = 10'h2b6, cur1, cur2;
    logic [5:0] fp = 6'h00;
    logic [1:0] run, m;
    int         err_total = 0, comparisons = 0, n;
    logic [7:0] rows [9][3] = '{'{8'h1e, 8'h09, 8'h09}, '{8'h1f, 8'hc0, 8'hc0},
        '{8'h24, 8'hff, 8'h03}, '{8'h25, 8'ha5, 8'ha5}, '{8'h26, 8'hff, 8'h03},
        '{8'h27, 8'h3c, 8'h3c}, '{8'h20, 8'hff, 8'h02}, '{8'h21, 8'h00, 8'had},
        '{8'h31, 8'hff, 8'h00}};
    always #12.5 mclk_i = ~mclk_i;
    always @(posedge mclk_i) #1 adc_valid_i = ~adc_valid_i;
    lhfr_bank #(.FT0_CYC(21'd20), .FT1_CYC(21'd40), .FT2_CYC(21'd80),
                .FT3_CYC(21'd160)) dut_u (.mclk_i(mclk_i), .reset_i(reset_i),
        .wr_i(wr_i), .rd_i(rd_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .rdata_o(rdata_o), .adc_valid_i(adc_valid_i), .adc_code_i(adc_code_i),
        .thermal_fault_i({fp[5], fp[2]}), .hs_limit_fault_i({fp[4], fp[1]}),
        .ls_limit_fault_i({fp[3], fp[0]}), .channel_run_o(run),
        .ch1_current_setting_o(cur1), .ch2_current_setting_o(cur2));
    lhfr_host host_u (.mclk_i(mclk_i), .rdata_i(rdata_o), .wr_o(wr_i),
        .rd_o(rd_i), .addr_o(addr_i), .wdata_o(wdata_i));
    task chk(input string what, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task cyc(input int k);
        repeat (k) @(posedge mclk_i);
        #1;
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        cyc(3);
        reset_i = 1'b0;
        host_u.get(8'h1e, 8'h1f, qa, qb);
        chk("reset", {run, qa, qb}, 24'h0);
        $display("test reset done");
        foreach (rows[i]) begin
            host_u.put(rows[i][0], rows[i][1]);
            host_u.get(rows[i][0], rows[i][0], qa, qb);
            chk("register", {qa, qb}, {2{rows[i][2]}});
        end
        chk("currents", {cur1, cur2}, {10'h297, 10'h0f3});
        $display("test table done");
        host_u.put(8'h1e, 8'h49);
        cyc(400);
        chk("ext currents", {cur1, cur2}, {2{10'h2b6}});
        host_u.get(8'h23, 8'h22, qa, qb);
        chk("filtered pair", {qa, qb}, 16'had02);
        adc_code_i = 10'h155;
        cyc(400);
        host_u.get(8'h22, 8'h22, qa, qb);
        chk("stale lower", {qa, qb}, 16'h0202);
        host_u.get(8'h21, 8'h23, qa, qb);
        chk("upper alone", {qa, qb}, 16'h5555);
        host_u.get(8'h23, 8'h22, qa, qb);
        chk("new pair", {qa, qb, cur1[7:0]}, 24'h550155);
        $display("test reference done");
        host_u.put(8'h1e, 8'h09);
        for (int i = 0; i < 12; i++) begin
            m = (i % 6 >= 3) ? 2'b10 : 2'b01;
            host_u.put(8'h1f, (i < 6) ? 8'h01 << i : 8'h00);
            fp = 6'h01 << (i % 6);
            cyc(8);
            chk("run in fault", run, {~m});
            fp = 6'h00;
            cyc(200);
            host_u.get(8'h1e, 8'h1e, qa, qb);
            chk("after fault", {run, qa}, (i < 6) ? {~m, 8'h09 & ~{m[1],
                2'b00, m[0]}} : {2'b11, 8'h09});
            host_u.put(8'h1e, 8'h09);
            cyc(4);
            chk("re-enabled", run, 2'b11);
        end
        $display("test faults done");
        for (int c = 0; c < 4; c++) begin
            host_u.put(8'h1f, 8'(c << 6));
            fp = 6'h10;
            cyc(6);
            fp = 6'h00;
            n = 0;
            while (run[1] !== 1'b1 && n < 400) begin
                cyc(1);
                n++;
            end
            chk("timer", n >= (20 << c) && n <= (20 << c) + 6, 1'b1);
        end
        $display("test timer done");
        reset_i = 1'b1;
        cyc(3);
        reset_i = 1'b0;
        host_u.get(8'h1e, 8'h1f, qa, qb);
        chk("second reset", {run, cur1, qa, qb}, 28'h0);
        $display("test second reset done");
        wrap_up();
    end
endmodule // tb
`default_nettype wire
